// ### src/lkd_top.sv
// LCD drive at 1/4 duty and 1/2 bias with a time-shared key matrix scanner.
// Assumes a Wishbone classic master and pads that turn level codes into voltages.
//
// Notes on behaviour
// - Four commons, quarter duty, half bias.
// - Three common levels, 2 ms steps, 62.5 Hz.
// - Reset and halt release hold commons mid.
// - Clearing blank bit starts common waveforms.
// - Four rows of 25 segments, 100 maximum.
// - Segments 17 to 25 each selectable as port.
// - Segments 22 to 25 carry key strobes, shared.
// - Four sense inputs read 16 keys.
// - Sense pull mode and 3-bit threshold programmable.
// - Software steps threshold for 3-bit conversion.
// - Pulled-down sense high cancels wait state.
// - Port one pins may output key strobes.
// - Port one input change wakes halt or wait.
// - Port one input change may set mute.
// - Backup mode forces commons, segments, port one, mute and wake low; irq_o and key_afe_o still follow the registers.
// - Shared pins come up as port inputs.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "lkd_consts.svh"
module lkd_top #(
	parameter int unsigned STEP_CYCLES = `LKD_STEP_NS / `LKD_CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone classic slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [7:0]           adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	output logic                      irq_o,
	// Power state from the core
	input  wire logic                 wait_i,
	input  wire logic                 halt_i,
	input  wire logic                 backup_i,
	output logic                      wake_o,
	// Display pins
	output lkd_pkg::lkd_level_t [3:0] com_o,
	output lkd_pkg::lkd_seg_pins_t    seg_o,
	input  wire logic [8:0]           seg_port_i,
	// Key sense front end
	input  wire logic [3:0]           key_cmp_i,
	output lkd_pkg::lkd_key_afe_t     key_afe_o,
	// Port one and mute
	input  wire logic [3:0]           p1_i,
	output logic      [3:0]           p1_o,
	output logic      [3:0]           p1_oe_o,
	output logic                      mute_o
);
	localparam int unsigned KEY_CYCLES = `LKD_KEY_SLOT_NS / `LKD_CLK_PERIOD_NS;
	localparam logic [23:0] STEP_LAST  = 24'(STEP_CYCLES - 1);
	localparam logic [23:0] KEY_FIRST  = 24'(STEP_CYCLES - KEY_CYCLES - 1);

	// Byte-lane merge for register writes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Common level for one line in the current step.
	function automatic lkd_pkg::lkd_level_t com_level(input logic chosen, input logic phase,
		input logic blank);
		if (blank || !chosen) begin
			return lkd_pkg::LVL_MID;
		end
		return phase ? lkd_pkg::LVL_GND : lkd_pkg::LVL_HIGH;
	endfunction : com_level

	// Synchronised pins.
	logic [8:0] port_s;
	logic [3:0] p1_s;
	logic [3:0] key_s;

	lkd_sync #(.W(17)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({seg_port_i, p1_i, key_cmp_i}),
		.q_o   ({port_s, p1_s, key_s})
	);

	// Registers.
	logic [3:0]  ctrl_q;
	logic [8:0]  psel_q;
	logic [8:0]  pdir_q;
	logic [8:0]  pout_q;
	logic [3:0]  p1dir_q;
	logic [3:0]  p1out_q;
	logic [10:0] kcfg_q;
	logic [15:0] key_q;
	logic [2:0]  istat_q;
	logic [2:0]  imask_q;
	logic [3:0]  p1_prev_q;
	logic        halt_prev_q;
	logic        busy_q;

	// Scan timing.
	logic [23:0]         step_cnt_q;
	logic [2:0]          step_q;
	lkd_pkg::lkd_state_t st_q;
	logic [24:0]         row_b;
	logic [24:0]         row_a;

	// Bus decode.
	wire       req      = cyc_i & stb_i & ~busy_q & ~ack_o;
	wire       commit   = busy_q & ~ack_o;
	wire       wr       = commit & we_i;
	wire       hit_ctrl = adr_i == `LKD_OFS_CTRL;
	wire       hit_psel = adr_i == `LKD_OFS_PSEL;
	wire       hit_pdir = adr_i == `LKD_OFS_PDIR;
	wire       hit_pout = adr_i == `LKD_OFS_POUT;
	wire       hit_pin  = adr_i == `LKD_OFS_PIN;
	wire       hit_p1   = adr_i == `LKD_OFS_P1;
	wire       hit_kcfg = adr_i == `LKD_OFS_KCFG;
	wire       hit_key  = adr_i == `LKD_OFS_KEY;
	wire       hit_ist  = adr_i == `LKD_OFS_ISTAT;
	wire       hit_imk  = adr_i == `LKD_OFS_IMASK;
	wire       hit_seg  = adr_i >= `LKD_OFS_SEG0 && adr_i <= `LKD_OFS_SEG3 && adr_i[1:0] == 2'h0;
	wire [1:0] seg_row  = adr_i[3:2];
	// Display rows are written whole; partial byte lanes leave the row alone.
	wire       seg_we   = wr & hit_seg & (sel_i == 4'hf);

	wire [31:0] wd_ctrl = merge({28'h0, ctrl_q}, dat_i, sel_i);
	wire [31:0] wd_psel = merge({23'h0, psel_q}, dat_i, sel_i);
	wire [31:0] wd_pdir = merge({23'h0, pdir_q}, dat_i, sel_i);
	wire [31:0] wd_pout = merge({23'h0, pout_q}, dat_i, sel_i);
	wire [31:0] wd_p1   = merge({24'h0, p1out_q, p1dir_q}, dat_i, sel_i);
	wire [31:0] wd_kcfg = merge({21'h0, kcfg_q}, dat_i, sel_i);
	wire [31:0] wd_ist  = merge(32'h0, dat_i, sel_i);
	wire [31:0] wd_imk  = merge({29'h0, imask_q}, dat_i, sel_i);

	wire [31:0] rd_data =
		hit_ctrl ? {28'h0, ctrl_q} :
		hit_psel ? {23'h0, psel_q} :
		hit_pdir ? {23'h0, pdir_q} :
		hit_pout ? {23'h0, pout_q} :
		hit_pin  ? {23'h0, port_s} :
		hit_p1   ? {20'h0, p1_s, p1out_q, p1dir_q} :
		hit_kcfg ? {21'h0, kcfg_q} :
		hit_key  ? {12'h0, key_s, key_q} :
		hit_ist  ? {29'h0, istat_q} :
		hit_imk  ? {29'h0, imask_q} :
		hit_seg  ? {7'h0, row_a} : 32'h0;

	lkd_seg_mem u_mem (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.we_i      (seg_we),
		.waddr_i   (seg_row),
		.wdata_i   (dat_i[24:0]),
		.raddr_a_i (seg_row),
		.rdata_a_o (row_a),
		.raddr_b_i (step_q[1:0]),
		.rdata_b_o (row_b)
	);

	wire step_end  = step_cnt_q == STEP_LAST;
	wire key_start = step_cnt_q == KEY_FIRST;
	wire in_key    = st_q == lkd_pkg::ST_KEY;
	wire phase     = step_q[2];
	wire [1:0] kidx = step_q[1:0];
	wire [3:0] strobe = in_key ? 4'(4'h1 << kidx) : 4'h0;
	wire frame_end = step_end & (step_q == 3'h7);

	always_ff @(posedge clk_i) begin
		if (rst_i || step_end) begin
			step_cnt_q <= 24'h0;
		end else begin
			step_cnt_q <= step_cnt_q + 24'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_q <= 3'h0;
		end else if (step_end) begin
			step_q <= step_q + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= lkd_pkg::ST_DISP;
		end else begin
			case (st_q)
				lkd_pkg::ST_DISP: st_q <= key_start ? lkd_pkg::ST_KEY : lkd_pkg::ST_DISP;
				lkd_pkg::ST_KEY:  st_q <= step_end ? lkd_pkg::ST_DISP : lkd_pkg::ST_KEY;
				default:          st_q <= lkd_pkg::ST_DISP;
			endcase
		end
	end

	// Events.
	wire [3:0] p1_in_chg = (p1_s ^ p1_prev_q) & ~p1dir_q;
	wire       p1_chg    = |p1_in_chg;
	logic [3:0] kpd_high;
	always_comb begin
		for (int k = 0; k < `LKD_NUM_KEY; k++) begin
			kpd_high[k] = key_s[k] & (key_afe_o.pull[k] == lkd_pkg::PULL_DOWN);
		end
	end
	wire       key_smp   = in_key & step_end;
	wire       key_chg   = key_smp & (key_q[kidx*4 +: 4] != key_s);
	wire [2:0] ev        = {frame_end, p1_chg, key_chg};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p1_prev_q   <= 4'h0;
			halt_prev_q <= 1'b0;
			key_q       <= 16'h0;
		end else begin
			p1_prev_q   <= p1_s;
			halt_prev_q <= halt_i;
			if (key_smp) begin
				key_q[kidx*4 +: 4] <= key_s;
			end
		end
	end

	// Control register: hardware sets win over software writes.
	logic [3:0] ctrl_d;
	always_comb begin
		ctrl_d = (wr && hit_ctrl) ? wd_ctrl[3:0] : ctrl_q;
		if (halt_prev_q && !halt_i) begin
			ctrl_d[`LKD_CTRL_BLANK] = 1'b1;
		end
		if (p1_chg && ctrl_q[`LKD_CTRL_MUTEEN]) begin
			ctrl_d[`LKD_CTRL_MUTE] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q  <= `LKD_RST_CTRL;
			psel_q  <= `LKD_RST_PSEL;
			pdir_q  <= 9'h0;
			pout_q  <= 9'h0;
			p1dir_q <= 4'h0;
			p1out_q <= 4'h0;
			kcfg_q  <= `LKD_RST_KCFG;
			istat_q <= 3'h0;
			imask_q <= 3'h0;
		end else begin
			ctrl_q <= ctrl_d;
			if (wr && hit_psel) psel_q <= wd_psel[8:0];
			if (wr && hit_pdir) pdir_q <= wd_pdir[8:0];
			if (wr && hit_pout) pout_q <= wd_pout[8:0];
			if (wr && hit_p1) begin
				p1dir_q <= wd_p1[3:0];
				p1out_q <= wd_p1[7:4];
			end
			if (wr && hit_kcfg) kcfg_q <= wd_kcfg[10:0];
			if (wr && hit_imk) imask_q <= wd_imk[2:0];
			istat_q <= (istat_q & ~((wr && hit_ist) ? wd_ist[2:0] : 3'h0)) | ev;
		end
	end

	// Bus handshake: request taken, then data and ack one cycle later.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			ack_o  <= 1'b0;
			dat_o  <= 32'h0;
		end else begin
			busy_q <= req | (busy_q & ~ack_o);
			ack_o  <= commit;
			if (commit) dat_o <= we_i ? 32'h0 : rd_data;
		end
	end

	// Pin drive.
	lkd_pkg::lkd_level_t [3:0] com_d;
	lkd_pkg::lkd_seg_pins_t    seg_d;
	always_comb begin
		for (int c = 0; c < `LKD_NUM_COM; c++) begin
			com_d[c] = com_level(kidx == 2'(c), phase, ctrl_q[`LKD_CTRL_BLANK]);
		end
		for (int s = 0; s < `LKD_NUM_SEG; s++) begin
			seg_d.lvl[s] = row_b[s] ^ ~phase;
			seg_d.oe[s]  = 1'b1;
			if (in_key && s >= `LKD_STROBE_BASE) begin
				seg_d.lvl[s] = strobe[`LKD_STROBE_TOP - s];
			end
			if (s >= `LKD_PORT_BASE && psel_q[s - `LKD_PORT_BASE]) begin
				seg_d.lvl[s] = pout_q[s - `LKD_PORT_BASE];
				seg_d.oe[s]  = pdir_q[s - `LKD_PORT_BASE];
			end
		end
	end

	wire [3:0] p1_d = (ctrl_q[`LKD_CTRL_P1STB] && in_key) ? strobe : p1out_q;
	wire wake_d = (wait_i & |kpd_high) | ((wait_i | halt_i) & p1_chg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			com_o     <= '{default: lkd_pkg::LVL_MID};
			seg_o     <= '{lvl: 25'h0, oe: 25'h0ffff};
			p1_o      <= 4'h0;
			p1_oe_o   <= 4'h0;
			mute_o    <= 1'b0;
			wake_o    <= 1'b0;
			irq_o     <= 1'b0;
			key_afe_o <= '0;
		end else if (backup_i) begin
			com_o     <= '{default: lkd_pkg::LVL_GND};
			seg_o     <= '{lvl: 25'h0, oe: 25'h1ffffff};
			p1_o      <= 4'h0;
			p1_oe_o   <= 4'hf;
			mute_o    <= 1'b0;
			wake_o    <= 1'b0;
			irq_o     <= |(istat_q & imask_q);
			key_afe_o <= lkd_pkg::lkd_key_afe_t'({kcfg_q[7:0], kcfg_q[10:8]});
		end else begin
			com_o     <= com_d;
			seg_o     <= seg_d;
			p1_o      <= p1_d;
			p1_oe_o   <= p1dir_q;
			mute_o    <= ctrl_q[`LKD_CTRL_MUTE];
			wake_o    <= wake_d;
			irq_o     <= |(istat_q & imask_q);
			key_afe_o <= lkd_pkg::lkd_key_afe_t'({kcfg_q[7:0], kcfg_q[10:8]});
		end
	end
endmodule : lkd_top

// ### src/lkd_consts.svh
// Constants of the LCD drive and key scan block: timing, field positions, offsets.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LKD_CONSTS_SVH
`define LKD_CONSTS_SVH

// Timing, in nanoseconds.
`define LKD_CLK_NS         100'd10
`define LKD_STEP_NS        2000000
`define LKD_KEY_SLOT_NS    20000
`define LKD_CLK_PERIOD_NS  10

// Geometry.
`define LKD_NUM_COM        4
`define LKD_NUM_SEG        25
`define LKD_NUM_PORT       9
`define LKD_PORT_BASE      16
`define LKD_STROBE_TOP     24
`define LKD_STROBE_BASE    21
`define LKD_NUM_KEY        4
`define LKD_NUM_P1         4

// Register byte offsets.
`define LKD_OFS_CTRL       8'h00
`define LKD_OFS_PSEL       8'h04
`define LKD_OFS_PDIR       8'h08
`define LKD_OFS_POUT       8'h0c
`define LKD_OFS_PIN        8'h10
`define LKD_OFS_P1         8'h14
`define LKD_OFS_KCFG       8'h18
`define LKD_OFS_KEY        8'h1c
`define LKD_OFS_ISTAT      8'h20
`define LKD_OFS_IMASK      8'h24
`define LKD_OFS_SEG0       8'h40
`define LKD_OFS_SEG3       8'h4c

// Control register fields.
`define LKD_CTRL_BLANK     0
`define LKD_CTRL_P1STB     1
`define LKD_CTRL_MUTEEN    2
`define LKD_CTRL_MUTE      3

// Interrupt bits.
`define LKD_IRQ_KEY        0
`define LKD_IRQ_P1         1
`define LKD_IRQ_FRAME      2

// Reset values.
`define LKD_RST_CTRL       4'h1
`define LKD_RST_PSEL       9'h1ff
`define LKD_RST_KCFG       11'h000

`endif

// ### src/lkd_pkg.sv
// Types shared by the LCD drive and key scan block.
// Assumes the constants header is on the include path.
`include "lkd_consts.svh"
package lkd_pkg;
	typedef enum logic [1:0] {
		LVL_GND  = 2'h0,
		LVL_MID  = 2'h1,
		LVL_HIGH = 2'h2
	} lkd_level_t;

	typedef enum logic [1:0] {
		PULL_NONE = 2'h0,
		PULL_DOWN = 2'h1,
		PULL_UP   = 2'h2
	} lkd_pull_t;

	typedef enum logic [1:0] {
		ST_DISP = 2'b01,
		ST_KEY  = 2'b10
	} lkd_state_t;

	// Settings for the analog key comparator front end.
	typedef struct packed {
		lkd_pull_t [3:0] pull;
		logic      [2:0] thresh;
	} lkd_key_afe_t;

	// Segment pin group: level and output enable per line.
	typedef struct packed {
		logic [24:0] lvl;
		logic [24:0] oe;
	} lkd_seg_pins_t;
endpackage : lkd_pkg

// ### src/lkd_sync.sv
// Two flip-flop synchroniser for a bus of pin inputs.
// Assumes each bit is an independent level; no word coherency is given.
`timescale 1ns/1ns
module lkd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule : lkd_sync

// ### src/lkd_seg_mem.sv
// Display memory: one row of segment bits per common line.
// Assumes one writer; both read ports return data one clock after the address.
`timescale 1ns/1ns
`include "lkd_consts.svh"
module lkd_seg_mem (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Write port
	input  wire logic        we_i,
	input  wire logic [1:0]  waddr_i,
	input  wire logic [24:0] wdata_i,
	// Bus read port
	input  wire logic [1:0]  raddr_a_i,
	output logic      [24:0] rdata_a_o,
	// Scan read port
	input  wire logic [1:0]  raddr_b_i,
	output logic      [24:0] rdata_b_o
);
	logic [24:0] mem_q [`LKD_NUM_COM];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_a_o <= '0;
			rdata_b_o <= '0;
		end else begin
			rdata_a_o <= mem_q[raddr_a_i];
			rdata_b_o <= mem_q[raddr_b_i];
		end
	end
endmodule : lkd_seg_mem

// ### testbench/lkd_properties.sv
// Port checks for the LCD drive and key scan block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module lkd_props #(
	parameter int unsigned STEP_CYCLES = 200000
) (
	// Clock, reset and bus
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      cyc_i,
	input wire logic                      stb_i,
	input wire logic                      ack_o,
	// Power state
	input wire logic                      wait_i,
	input wire logic                      halt_i,
	input wire logic                      backup_i,
	input wire logic                      wake_o,
	// Pins
	input wire lkd_pkg::lkd_level_t [3:0] com_o,
	input wire lkd_pkg::lkd_seg_pins_t    seg_o,
	input wire logic [3:0]                key_cmp_i,
	input wire lkd_pkg::lkd_key_afe_t     key_afe_o,
	input wire logic [3:0]                p1_i,
	input wire logic [3:0]                p1_o,
	input wire logic [3:0]                p1_oe_o,
	input wire logic                      mute_o
);
	logic [3:0] active;
	logic [3:0] pulled;

	always_comb begin
		for (int c = 0; c < 4; c++) begin
			active[c] = com_o[c] != lkd_pkg::LVL_MID;
			pulled[c] = key_afe_o.pull[c] == lkd_pkg::PULL_DOWN;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack stood longer than one cycle");
	a_ack_latency: assert property ($rose(cyc_i && stb_i) |-> !ack_o ##1 !ack_o ##1 ack_o)
		else $error("ack not two edges after request");
	a_reset_state:
		assert property ($fell(rst_i) |-> com_o == 8'h55 && seg_o.oe == 25'h0ffff)
		else $error("wrong pin state after reset");
	a_backup_low:
		assert property (backup_i |=> com_o == 8'h00 && seg_o == 50'h1ff_ffff
			&& &p1_oe_o && p1_o == 4'h0 && !mute_o)
		else $error("outputs not low in backup");
	a_one_common:
		assert property (!backup_i && !$past(backup_i) |-> $countones(active) <= 1)
		else $error("more than one common active");
	a_com_steady:
		assert property ($changed(com_o) && !$past(backup_i) |=> $stable(com_o) [*8])
		else $error("common level changed too soon");
	a_wake_port:
		assert property (halt_i && |((p1_i ^ $past(p1_i)) & ~p1_oe_o) |-> ##[1:5] wake_o)
		else $error("port one change did not wake");
	a_wake_sense:
		assert property ($rose(wait_i && |(key_cmp_i & pulled)) |-> ##[1:5] wake_o)
		else $error("pulled-down sense did not wake");
endmodule : lkd_props

bind lkd_top lkd_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.wait_i(wait_i), .halt_i(halt_i), .backup_i(backup_i), .wake_o(wake_o),
	.com_o(com_o), .seg_o(seg_o), .key_cmp_i(key_cmp_i), .key_afe_o(key_afe_o),
	.p1_i(p1_i), .p1_o(p1_o), .p1_oe_o(p1_oe_o), .mute_o(mute_o)
);

// ### testbench/lkd_glass.sv
// Behavioural LCD glass and passive key matrix on the segment and sense pins.
// Assumes strobes are active high; a comparator is high when the key voltage is above it.
`timescale 1ns/1ns
module lkd_glass (
	// Pins from the block
	input  wire lkd_pkg::lkd_seg_pins_t seg_i,
	input  wire lkd_pkg::lkd_key_afe_t  afe_i,
	// Scenario controls
	input  wire logic [15:0]            keys_i,
	input  wire logic [11:0]            level_i,
	input  wire logic [8:0]             ext_i,
	// Pins into the block
	output logic      [3:0]             cmp_o,
	output logic      [8:0]             port_o
);
	// A pressed key joins its strobe line to its sense line; a pull-up reads high.
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			cmp_o[k] = level_i[3*k+:3] > afe_i.thresh || afe_i.pull[k] == lkd_pkg::PULL_UP;
			for (int s = 0; s < 4; s++) begin
				cmp_o[k] = cmp_o[k] | (keys_i[4*s+k] & seg_i.lvl[24-s] & seg_i.oe[24-s]);
			end
		end
		for (int p = 0; p < 9; p++) begin
			port_o[p] = seg_i.oe[16+p] ? seg_i.lvl[16+p] : ext_i[p];
		end
	end
endmodule : lkd_glass

// ### testbench/tb_lcd_drive_and_key_scan.sv
// Register-level bench for the LCD drive and key scan block.
// Assumes the glass model on the pins and a shortened step count.
`timescale 1ns/1ns
module tb_lcd_drive_and_key_scan;
	localparam int STEP = 2400;
	logic                      clk_i = 1'b0;
	logic                      rst_i = 1'b1;
	logic                      cyc_i = 1'b0;
	logic                      stb_i = 1'b0;
	logic                      we_i = 1'b0;
	logic [7:0]                adr_i = 8'h00;
	logic [31:0]               dat_i = 32'h0;
	logic                      wait_i = 1'b0;
	logic                      halt_i = 1'b0;
	logic                      backup_i = 1'b0;
	logic [3:0]                p1_i = 4'h0;
	logic [3:0]                sel_i = 4'h0;
	logic [15:0]               keys = 16'h0;
	logic [31:0]               dat_o, q;
	logic                      ack_o, irq_o, wake_o, mute_o;
	logic [3:0]                key_cmp_i, p1_o, p1_oe_o;
	logic [8:0]                seg_port_i;
	lkd_pkg::lkd_level_t [3:0] com_o;
	lkd_pkg::lkd_seg_pins_t    seg_o;
	lkd_pkg::lkd_key_afe_t     key_afe_o;
	int                        miscompares = 0;
	int                        n_compared = 0;
	int                        n, r;

	always #5 clk_i = ~clk_i;

	lkd_top #(.STEP_CYCLES(STEP)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.irq_o(irq_o), .wait_i(wait_i), .halt_i(halt_i), .backup_i(backup_i),
		.wake_o(wake_o), .com_o(com_o), .seg_o(seg_o), .seg_port_i(seg_port_i),
		.key_cmp_i(key_cmp_i), .key_afe_o(key_afe_o), .p1_i(p1_i), .p1_o(p1_o),
		.p1_oe_o(p1_oe_o), .mute_o(mute_o));
	lkd_glass glass (.seg_i(seg_o), .afe_i(key_afe_o), .keys_i(keys), .level_i(12'h005),
		.ext_i(9'h000), .cmp_o(key_cmp_i), .port_o(seg_port_i));

	function automatic logic [31:0] row(input int i);
		return (32'h01c3_5a69 ^ (32'h1111 * i)) & 32'h1ff_ffff;
	endfunction : row

	task close_out;
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hf;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		cmp(q & m, e);
	endtask : rd_chk

	task wait_step;
		lkd_pkg::lkd_level_t [3:0] prev;
		prev = com_o;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (com_o === prev);
	endtask : wait_step

	task wait_wake;
		n = 0;
		while (wake_o !== 1'b1 && n < 8) begin
			@(posedge clk_i);
			n++;
		end
		cmp(wake_o, 1'b1);
	endtask : wait_wake

	initial begin
		repeat (90000) @(posedge clk_i);
		miscompares++;
		close_out;
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		cmp(32'(com_o), 32'h55);
		cmp(seg_o.oe, 32'h0ffff);
		rd_chk(8'h00, 32'hf, 32'h1);
		rd_chk(8'h04, 32'h1ff, 32'h1ff);
		rd_chk(8'h18, 32'h7ff, 32'h0);
		wb(1'b1, 8'h3c, 32'hffff_ffff);
		rd_chk(8'h3c, 32'hffff_ffff, 32'h0);
		for (r = 0; r < 4; r++) wb(1'b1, 8'h40 + 8'(4 * r), row(r));
		for (r = 0; r < 4; r++) rd_chk(8'h40 + 8'(4 * r), 32'h1ff_ffff, row(r));
		// Successive approximation of a 5 on sense 0.
		r = 0;
		for (int b = 2; b >= 0; b--) begin
			wb(1'b1, 8'h18, 32'(r + (1 << b) - 1) << 8);
			repeat (4) @(posedge clk_i);
			wb(1'b0, 8'h1c, 32'h0);
			if (q[16] === 1'b1) r += 1 << b;
		end
		cmp(r, 5);
		wb(1'b1, 8'h18, 32'h009);
		repeat (4) @(posedge clk_i);
		cmp(32'(key_afe_o), 32'h48);
		wait_i <= 1'b1;
		wait_wake;
		wait_i <= 1'b0;
		wb(1'b1, 8'h04, 32'h001);
		wb(1'b1, 8'h08, 32'h001);
		wb(1'b1, 8'h0c, 32'h001);
		wb(1'b1, 8'h18, 32'h700);
		wb(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge clk_i);
		cmp({seg_o.oe[24:16], seg_o.lvl[16]}, 32'h3ff);
		rd_chk(8'h10, 32'h1, 32'h1);
		while (com_o[0] !== lkd_pkg::LVL_HIGH) @(posedge clk_i);
		wait_step;
		cmp(32'(com_o), 32'h59);
		repeat (100) @(posedge clk_i);
		cmp(seg_o.lvl[15:0], ~row(1) & 32'hffff);
		wait_step;
		// The count starts 100 cycles into the step, after the segment check.
		cmp(n, STEP - 100);
		cmp(32'(com_o), 32'h65);
		wait_step;
		wait_step;
		cmp(32'(com_o), 32'h54);
		repeat (100) @(posedge clk_i);
		cmp(seg_o.lvl[15:0], row(0) & 32'hffff);
		keys <= 16'h0040;
		wb(1'b1, 8'h24, 32'h1);
		repeat (5 * STEP) @(posedge clk_i);
		rd_chk(8'h1c, 32'hffff, 32'h0040);
		rd_chk(8'h20, 32'h1, 32'h1);
		cmp(irq_o, 1'b1);
		wb(1'b1, 8'h24, 32'h0);
		repeat (3) @(posedge clk_i);
		cmp(irq_o, 1'b0);
		wb(1'b1, 8'h20, 32'h1);
		wb(1'b1, 8'h24, 32'h1);
		repeat (3) @(posedge clk_i);
		cmp(irq_o, 1'b0);
		wb(1'b1, 8'h14, 32'h11);
		repeat (3) @(posedge clk_i);
		cmp({p1_oe_o, p1_o}, 32'h11);
		wb(1'b1, 8'h00, 32'h4);
		halt_i <= 1'b1;
		@(posedge clk_i);
		p1_i <= 4'h2;
		wait_wake;
		repeat (3) @(posedge clk_i);
		cmp(mute_o, 1'b1);
		rd_chk(8'h20, 32'h2, 32'h2);
		halt_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		cmp(32'(com_o), 32'h55);
		rd_chk(8'h00, 32'h1, 32'h1);
		backup_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		cmp(32'(com_o), 32'h0);
		cmp({seg_o.lvl, p1_o}, 32'h0);
		cmp(seg_o.oe, 32'h1ff_ffff);
		backup_i <= 1'b0;
		close_out;
	end
endmodule : tb_lcd_drive_and_key_scan
